/* irq_ctrl_pkg.sv */
// package: register map, bit positions and timing of the interrupt controller
// assumes: 32-bit ahb-lite register bus, 50 MHz i_mclk
package irq_ctrl_pkg;

  // register byte addresses (index times four; printed offsets not words)
  localparam int unsigned ICTL_IDX_LO = 32'h0000000b;
  localparam int unsigned ICTL_IDX_HI = 32'h0000008b;
  localparam int unsigned PFLG_IDX    = 32'h0000000c;
  localparam int unsigned PENA_IDX    = 32'h0000008c;
  localparam int unsigned CORE_IDX    = 32'h000000c0;
  localparam logic [11:0] ICTL_ADDR_LO = 12'(ICTL_IDX_LO * 4);
  localparam logic [11:0] ICTL_ADDR_HI = 12'(ICTL_IDX_HI * 4);
  localparam logic [11:0] PFLG_ADDR    = 12'(PFLG_IDX * 4);
  localparam logic [11:0] PENA_ADDR    = 12'(PENA_IDX * 4);
  localparam logic [11:0] CORE_ADDR    = 12'(CORE_IDX * 4);

  // interrupt_control bits
  localparam int GLB_EN_BIT = 7;
  localparam int PER_EN_BIT = 6;
  localparam int T0E_BIT  = 5;
  localparam int EXE_BIT  = 4;
  localparam int PCE_BIT  = 3;
  localparam int T0F_BIT  = 2;
  localparam int EXF_BIT  = 1;
  localparam int PCF_BIT  = 0;
  // peripheral flag/enable bits
  localparam int EEW_BIT  = 7;
  localparam int ADC_BIT  = 6;
  localparam int CMP_BIT  = 3;
  localparam int TM1_BIT  = 0;
  localparam logic [7:0] PERIPH_MASK = 8'hc9;
  // core control register bits
  localparam int EDGE_BIT = 0;
  localparam int SLP_BIT  = 1;

  localparam logic [7:0]  ICTL_RST    = 8'h00;
  localparam logic [7:0]  PREG_RST    = 8'h00;
  localparam logic [7:0]  TMR_ROLL_HI = 8'hff;
  localparam logic [7:0]  TMR_ROLL_LO = 8'h00;
  localparam logic [15:0] IRQ_VECTOR  = 16'h0004;
  localparam logic [1:0]  HTRANS_NSEQ = 2'b10;
  localparam logic [2:0]  HSIZE_WORD  = 3'b010;

  // timing: instruction cycle is four i_mclk cycles (q1..q4)
  localparam int TCY_NS      = 80;
  localparam int CLK_NS      = 20;
  localparam int Q_PER_TCY   = TCY_NS / CLK_NS;
  localparam int LAT_TCY     = 3;
  localparam logic [3:0] LAT_CYCLES = 4'(LAT_TCY * Q_PER_TCY);

  typedef enum logic [1:0] {
    Q1 = 2'b00,
    Q2 = 2'b01,
    Q3 = 2'b10,
    Q4 = 2'b11
  } qphase_t;

  typedef struct packed {
    logic ext_pin;
    logic timer0_roll;
    logic adc_done;
    logic cmp_change;
    logic tmr1_roll;
    logic eeprom_done;
  } src_events_t;

  typedef struct packed {
    logic        vector_req;
    logic [15:0] vector_addr;
    logic        wake;
  } core_req_t;

endpackage

/* irq_ctrl.sv */
// interrupt controller of an 8-bit microcontroller core
// assumes: ahb-lite single slave, peripherals and core on i_mclk,
// ext pin and port pins asynchronous
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps

module irq_ctrl #(
  parameter int PORT_W = 6
) (
  input  wire logic                      i_mclk,
  input  wire logic                      i_rst,
  input  wire logic                      i_por,
  input  wire logic [31:0]               i_haddr,
  input  wire logic [1:0]                i_htrans,
  input  wire logic                      i_hwrite,
  input  wire logic [2:0]                i_hsize,
  input  wire logic [31:0]               i_hwdata,
  input  wire logic                      i_hsel,
  input  wire logic                      i_hready,
  output logic [31:0]                    o_hrdata,
  output logic                           o_hreadyout,
  output logic                           o_hresp,
  input  wire logic                      i_ext_irq_pin,
  input  wire logic [PORT_W-1:0]         i_port_pins,
  input  wire logic [PORT_W-1:0]         i_per_pin_change_mask,
  input  wire logic [7:0]                i_timer0_count,
  input  wire irq_ctrl_pkg::src_events_t i_events,
  input  wire logic                      i_return_from_interrupt,
  input  wire logic [15:0]               i_return_pc,
  output irq_ctrl_pkg::core_req_t        o_core,
  output logic [15:0]                    o_saved_pc,
  output logic [1:0]                     o_qphase
);

  default clocking chk_cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  // ------------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------------
  logic        wr_pend_reg;
  logic [11:0] wr_addr_reg;
  logic        rd_pend_reg;
  logic [11:0] rd_addr_reg;
  wire         take      = i_hsel && i_hready &&
                           i_htrans == irq_ctrl_pkg::HTRANS_NSEQ;
  wire  [11:0] a_addr    = i_haddr[11:0];
  wire         sel_ictl  = wr_addr_reg == irq_ctrl_pkg::ICTL_ADDR_LO ||
                           wr_addr_reg == irq_ctrl_pkg::ICTL_ADDR_HI;
  wire         wr_ictl   = wr_pend_reg && sel_ictl;
  wire         wr_pflg   = wr_pend_reg &&
                           wr_addr_reg == irq_ctrl_pkg::PFLG_ADDR;
  wire         wr_pena   = wr_pend_reg &&
                           wr_addr_reg == irq_ctrl_pkg::PENA_ADDR;
  wire         wr_core   = wr_pend_reg &&
                           wr_addr_reg == irq_ctrl_pkg::CORE_ADDR;
  wire  [7:0]  wdat      = i_hwdata[7:0];

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
      rd_addr_reg <= 12'h000;
    end else begin
      wr_pend_reg <= take && i_hwrite;
      rd_pend_reg <= take && !i_hwrite;
      wr_addr_reg <= a_addr;
      rd_addr_reg <= a_addr;
    end
  end

  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  // ------------------------------------------------------------------
  // instruction phase counter
  // ------------------------------------------------------------------
  irq_ctrl_pkg::qphase_t q_reg;
  irq_ctrl_pkg::qphase_t q_next;
  always_comb begin
    unique case (q_reg)
      irq_ctrl_pkg::Q1: q_next = irq_ctrl_pkg::Q2;
      irq_ctrl_pkg::Q2: q_next = irq_ctrl_pkg::Q3;
      irq_ctrl_pkg::Q3: q_next = irq_ctrl_pkg::Q4;
      irq_ctrl_pkg::Q4: q_next = irq_ctrl_pkg::Q1;
    endcase
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) q_reg <= irq_ctrl_pkg::Q1;
    else       q_reg <= q_next;
  end
  assign o_qphase = q_reg;

  // ------------------------------------------------------------------
  // pin synchronisers and edge detection
  // ------------------------------------------------------------------
  logic              ext_s1_reg;
  logic              ext_s2_reg;
  logic              ext_d_reg;
  logic [PORT_W-1:0] port_s1_reg;
  logic [PORT_W-1:0] port_s2_reg;
  logic [PORT_W-1:0] port_latch_reg;
  logic [7:0]        tmr_d_reg;
  logic [7:0]        core_ctl_reg;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ext_s1_reg  <= 1'b0;
      ext_s2_reg  <= 1'b0;
      ext_d_reg   <= 1'b0;
      port_s1_reg <= '0;
      port_s2_reg <= '0;
      tmr_d_reg   <= irq_ctrl_pkg::TMR_ROLL_LO;
    end else begin
      ext_s1_reg  <= i_ext_irq_pin;
      ext_s2_reg  <= ext_s1_reg;
      ext_d_reg   <= ext_s2_reg;
      port_s1_reg <= i_port_pins;
      port_s2_reg <= port_s1_reg;
      tmr_d_reg   <= i_timer0_count;
    end
  end

  wire edge_rise = core_ctl_reg[irq_ctrl_pkg::EDGE_BIT];
  wire ext_edge  = edge_rise ? (ext_s2_reg && !ext_d_reg)
                             : (!ext_s2_reg && ext_d_reg);
  wire ext_win   = q_reg == irq_ctrl_pkg::Q4 || q_reg == irq_ctrl_pkg::Q1;
  wire tmr_roll  = (tmr_d_reg == irq_ctrl_pkg::TMR_ROLL_HI &&
                    i_timer0_count == irq_ctrl_pkg::TMR_ROLL_LO) ||
                   i_events.timer0_roll;
  wire [PORT_W-1:0] port_diff = (port_s2_reg ^ port_latch_reg) &
                                i_per_pin_change_mask;
  // latch refreshed at q2 end drops change
  wire port_rd   = q_reg == irq_ctrl_pkg::Q2;
  wire port_chg  = |port_diff && !port_rd;

  always_ff @(posedge i_mclk) begin
    if (i_rst)        port_latch_reg <= '0;
    else if (port_rd) port_latch_reg <= port_s2_reg;
  end

  // ------------------------------------------------------------------
  // flag and enable registers
  // ------------------------------------------------------------------
  logic [7:0]  ictl_reg;
  logic [7:0]  ictl_next;
  logic [7:0]  pflg_reg;
  logic [7:0]  pflg_next;
  logic [7:0]  pena_reg;
  logic        accept;

  // seven sources, hardware sets beat clears
  wire [7:0] pflg_set = {i_events.eeprom_done, i_events.adc_done, 2'b00,
                         i_events.cmp_change, 2'b00, i_events.tmr1_roll};
  wire [7:0] ictl_set = {5'b00000, tmr_roll, ext_edge && ext_win, port_chg};

  always_comb begin
    ictl_next = ictl_reg;
    if (wr_ictl) ictl_next = wdat;
    ictl_next = ictl_next | ictl_set;
    if (i_return_from_interrupt) ictl_next[irq_ctrl_pkg::GLB_EN_BIT] = 1'b1;
    if (accept) ictl_next[irq_ctrl_pkg::GLB_EN_BIT] = 1'b0;
  end

  always_comb begin
    pflg_next = pflg_reg;
    if (wr_pflg) pflg_next = wdat;
    pflg_next = (pflg_next | pflg_set) & irq_ctrl_pkg::PERIPH_MASK;
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      // reset clears, warm keeps port flag
      ictl_reg <= irq_ctrl_pkg::ICTL_RST;
      if (!i_por) ictl_reg[irq_ctrl_pkg::PCF_BIT] <=
                   ictl_reg[irq_ctrl_pkg::PCF_BIT];
      pflg_reg     <= irq_ctrl_pkg::PREG_RST;
      pena_reg     <= irq_ctrl_pkg::PREG_RST;
      core_ctl_reg <= irq_ctrl_pkg::PREG_RST;
    end else begin
      ictl_reg <= ictl_next;
      pflg_reg <= pflg_next;
      if (wr_pena) pena_reg <= wdat & irq_ctrl_pkg::PERIPH_MASK;
      if (wr_core) core_ctl_reg <= wdat;
    end
  end

  // ------------------------------------------------------------------
  // request gating and vectoring
  // ------------------------------------------------------------------
  // individual enables
  wire main_req  = (ictl_reg[irq_ctrl_pkg::T0E_BIT] &&
                    ictl_reg[irq_ctrl_pkg::T0F_BIT]) ||
                   (ictl_reg[irq_ctrl_pkg::EXE_BIT] &&
                    ictl_reg[irq_ctrl_pkg::EXF_BIT]) ||
                   (ictl_reg[irq_ctrl_pkg::PCE_BIT] &&
                    ictl_reg[irq_ctrl_pkg::PCF_BIT]);
  wire per_any   = |(pflg_reg & pena_reg);
  wire per_req   = per_any && ictl_reg[irq_ctrl_pkg::PER_EN_BIT];
  wire wake_src  = main_req || per_any;
  wire gated     = (main_req || per_req) && ictl_reg[irq_ctrl_pkg::GLB_EN_BIT];

  logic [3:0]  lat_cnt_reg;
  logic        pend_reg;
  logic [15:0] saved_pc_reg;
  logic        vec_reg;

  // sampled at q1; a cleared enable aborts the wait
  wire sample    = q_reg == irq_ctrl_pkg::Q1;
  // vector three instruction cycles after sample
  assign accept  = pend_reg && lat_cnt_reg == irq_ctrl_pkg::LAT_CYCLES - 4'h1
                   && gated;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      pend_reg       <= 1'b0;
      lat_cnt_reg    <= 4'h0;
    end else begin
      if (!gated || accept) begin
        pend_reg    <= 1'b0;
        lat_cnt_reg <= 4'h0;
      end else if (!pend_reg && sample) begin
        pend_reg    <= 1'b1;
        lat_cnt_reg <= 4'h1;
      end else if (pend_reg) begin
        lat_cnt_reg <= lat_cnt_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      saved_pc_reg <= 16'h0000;
      vec_reg      <= 1'b0;
    end else begin
      vec_reg <= accept;
      if (accept) saved_pc_reg <= i_return_pc;
    end
  end

  assign o_core.vector_req  = vec_reg;
  assign o_core.vector_addr = irq_ctrl_pkg::IRQ_VECTOR;
  // wake while sleeping with enabled source
  assign o_core.wake        = wake_src && core_ctl_reg[irq_ctrl_pkg::SLP_BIT];
  assign o_saved_pc         = saved_pc_reg;

  // ------------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------------
  wire [7:0] rd_byte =
    (rd_addr_reg == irq_ctrl_pkg::ICTL_ADDR_LO ||
     rd_addr_reg == irq_ctrl_pkg::ICTL_ADDR_HI) ? ictl_reg :
    rd_addr_reg == irq_ctrl_pkg::PFLG_ADDR ? pflg_reg :
    rd_addr_reg == irq_ctrl_pkg::PENA_ADDR ? pena_reg :
    rd_addr_reg == irq_ctrl_pkg::CORE_ADDR ? core_ctl_reg : 8'h00;
  assign o_hrdata = rd_pend_reg ? {24'h000000, rd_byte} : 32'h00000000;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  wire glb_en = ictl_reg[irq_ctrl_pkg::GLB_EN_BIT];
  wire per_en = ictl_reg[irq_ctrl_pkg::PER_EN_BIT];

  chk_vector_needs_en: assert property (vec_reg |-> $past(glb_en))
    else $error("vector without global enable");
  chk_accept_clears_en: assert property (
    accept && !wr_ictl |=> !glb_en)
    else $error("global enable not cleared on accept");
  chk_return_sets_en: assert property (
    i_return_from_interrupt && !accept |=> glb_en)
    else $error("return did not set global enable");
  chk_reset_clears_en: assert property ($past(i_rst) |-> !glb_en)
    else $error("reset left global enable set");
  chk_adc_flag_set: assert property (
    i_events.adc_done |=> pflg_reg[irq_ctrl_pkg::ADC_BIT])
    else $error("adc flag not set");
  chk_eeprom_flag_set: assert property (
    i_events.eeprom_done |=> pflg_reg[irq_ctrl_pkg::EEW_BIT])
    else $error("eeprom flag not set");
  chk_cmp_flag_set: assert property (
    i_events.cmp_change |=> pflg_reg[irq_ctrl_pkg::CMP_BIT])
    else $error("comparator flag not set");
  chk_tm1_flag_set: assert property (
    i_events.tmr1_roll |=> pflg_reg[irq_ctrl_pkg::TM1_BIT])
    else $error("timer1 flag not set");
  chk_unused_zero: assert property (
    (pflg_reg & ~irq_ctrl_pkg::PERIPH_MASK) == 8'h00)
    else $error("unused peripheral bit set");
  chk_unused_en_zero: assert property (
    (pena_reg & ~irq_ctrl_pkg::PERIPH_MASK) == 8'h00)
    else $error("unused peripheral enable set");
  chk_latency_fixed: assert property (accept |-> $past(sample, 11))
    else $error("latency not three instruction cycles");
  chk_peri_gate: assert property (
    vec_reg && !$past(main_req) |-> $past(per_en))
    else $error("peripheral request without enable");
  chk_ext_window: assert property (
    $rose(ictl_reg[irq_ctrl_pkg::EXF_BIT]) && !$past(wr_ictl) |->
    $past(ext_win))
    else $error("ext flag set outside q4-q1");
  chk_ext_edge_flag: assert property (
    ext_edge && ext_win |=> ictl_reg[irq_ctrl_pkg::EXF_BIT])
    else $error("ext edge did not set flag");
  chk_timer_roll_flag: assert property (
    tmr_roll |=> ictl_reg[irq_ctrl_pkg::T0F_BIT])
    else $error("timer0 rollover did not set flag");
  chk_port_chg_flag: assert property (
    port_chg |=> ictl_reg[irq_ctrl_pkg::PCF_BIT])
    else $error("port change did not set flag");
  chk_off_no_vector: assert property (!glb_en |=> !vec_reg)
    else $error("vector while global enable clear");
  chk_vector_pulse: assert property (vec_reg |=> !vec_reg)
    else $error("vector request longer than one cycle");
  chk_saved_pc: assert property (
    vec_reg |-> saved_pc_reg == $past(i_return_pc))
    else $error("saved pc differs from return pc");
  chk_mirror_read: assert property (
    rd_pend_reg && rd_addr_reg == irq_ctrl_pkg::ICTL_ADDR_HI |->
    o_hrdata[7:0] == ictl_reg)
    else $error("mirror address read wrong value");
  chk_wake_any_en: assert property (
    core_ctl_reg[irq_ctrl_pkg::SLP_BIT] && per_any |-> o_core.wake)
    else $error("enabled source did not wake core");

endmodule

/* core_model.sv */
// partner model: core sequencer and peripheral event sources
// assumes: shares i_mclk with the controller; bench calls its tasks
`timescale 1ns/1ps
module core_model (
  input  wire logic                    i_mclk,
  input  wire irq_ctrl_pkg::core_req_t i_core,
  output irq_ctrl_pkg::src_events_t    o_events,
  output logic                         o_return_from_interrupt,
  output logic [15:0]                  o_return_pc,
  output logic [7:0]                   o_timer0_count,
  output int                           o_n_vec
);
  initial begin
    o_events = '0;
    o_return_from_interrupt = 1'b0;
    o_return_pc = 16'h0123;
    o_timer0_count = 8'h00;
    o_n_vec = 0;
  end
  // ----------------------------------------
  // vector counting
  // ----------------------------------------
  always @(posedge i_mclk) begin
    if (i_core.vector_req === 1'b1) begin
      o_n_vec <= o_n_vec + 1;
      // next service call comes from another site
      o_return_pc <= o_return_pc + 16'h0010;
    end
  end
  // ----------------------------------------
  // stimulus tasks
  // ----------------------------------------
  // one-cycle event pulse, idx is the bit in the event struct
  task automatic pulse(input int idx);
    @(posedge i_mclk);
    o_events <= irq_ctrl_pkg::src_events_t'(6'h01 << idx);
    @(posedge i_mclk);
    o_events <= '0;
  endtask
  task automatic ret();
    @(posedge i_mclk);
    o_return_from_interrupt <= 1'b1;
    @(posedge i_mclk);
    o_return_from_interrupt <= 1'b0;
  endtask
  task automatic tick(input logic [7:0] v);
    @(posedge i_mclk);
    o_timer0_count <= v;
  endtask
endmodule

/* tb.sv */
// testbench: registers, flags, vectoring and resets of irq_ctrl
// assumes: one 50 MHz clock, core_model stands for core and sources
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
  n_mismatch++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
  localparam logic [11:0] AI = irq_ctrl_pkg::ICTL_ADDR_LO;
  localparam logic [11:0] AH = irq_ctrl_pkg::ICTL_ADDR_HI;
  localparam logic [11:0] AF = irq_ctrl_pkg::PFLG_ADDR;
  localparam logic [11:0] AE = irq_ctrl_pkg::PENA_ADDR;
  localparam logic [11:0] AC = irq_ctrl_pkg::CORE_ADDR;
  typedef struct packed {logic w; logic [11:0] a; logic [7:0] d;} row_t;
  logic                      clk, rst, por, hwrite, hsel, pin, hready;
  logic                      hresp, rfi;
  logic [31:0]               haddr, hwdata, hrdata;
  logic [1:0]                htrans, qph;
  logic [2:0]                hsize;
  logic [5:0]                port, mask;
  logic [15:0]               spc, rpc;
  logic [7:0]                t0;
  irq_ctrl_pkg::src_events_t ev;
  irq_ctrl_pkg::core_req_t   core;
  int                        n_mismatch, checked, nv, n, k;
  row_t                      rows [9];
  int                        evi [4] = '{3, 2, 1, 0};
  logic [7:0]                fb [4] = '{8'h40, 8'h08, 8'h01, 8'h80};

  irq_ctrl #(.PORT_W(6)) dut (.i_mclk(clk), .i_rst(rst), .i_por(por),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(hsize), .i_hwdata(hwdata), .i_hsel(hsel), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .i_ext_irq_pin(pin), .i_port_pins(port),
    .i_per_pin_change_mask(mask), .i_timer0_count(t0), .i_events(ev),
    .i_return_from_interrupt(rfi), .i_return_pc(rpc), .o_core(core),
    .o_saved_pc(spc), .o_qphase(qph));
  core_model cm (.i_mclk(clk), .i_core(core), .o_events(ev),
    .o_return_from_interrupt(rfi), .o_return_pc(rpc),
    .o_timer0_count(t0), .o_n_vec(nv));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #200000;
    n_mismatch++;
    results();
  end
  // ----------------------------------------
  // bus and helper tasks
  // ----------------------------------------
  task automatic hrdy();
    int c;
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (hready !== 1'b1 && c < 50);
  endtask
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [7:0] d, output logic [31:0] r);
    haddr  <= {20'h0, a};
    htrans <= irq_ctrl_pkg::HTRANS_NSEQ;
    hwrite <= w;
    hrdy();
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    hrdy();
    r = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    logic [31:0] r;
    bus(1'b0, a, 8'h00, r);
    `CHK("rdata", {24'h0, e}, r)
  endtask
  task automatic reset(input logic p, input int c);
    rst <= 1'b1;
    por <= p;
    repeat (c) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask
  // drive the pin so its edge lands in the q4/q1 window
  task automatic pin_at(input logic v);
    int c;
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (qph !== irq_ctrl_pkg::Q1 && c < 8);
    pin <= v;
    repeat (8) @(posedge clk);
  endtask
  task automatic wvec();
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (core.vector_req !== 1'b1 && n < 40);
  endtask
  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    por = 1'b1;
    haddr = '0;
    hwdata = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsel = 1'b1;
    hsize = irq_ctrl_pkg::HSIZE_WORD;
    pin = 1'b0;
    port = '0;
    mask = '0;
    n_mismatch = 0;
    checked = 0;
    rows = '{'{0, AI, 8'h00}, '{0, AF, 8'h00}, '{0, AE, 8'h00},
             '{1, AE, 8'hff}, '{0, AE, 8'hc9}, '{1, AI, 8'h78},
             '{0, AH, 8'h78}, '{1, 12'h100, 8'hff}, '{0, 12'h100, 8'h00}};
    reset(1'b1, 20);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else rd(rows[i].a, rows[i].d);
    end
    hsel <= 1'b0;
    wr(AI, 8'hff);
    hsel <= 1'b1;
    rd(AH, 8'h78);
    done("regs");
    for (int i = 0; i < 4; i++) begin
      cm.pulse(evi[i]);
      rd(AF, fb[i]);
      wr(AF, 8'h00);
    end
    cm.tick(8'hff);
    cm.tick(8'h00);
    rd(AI, 8'h7c);
    wr(AI, 8'h78);
    for (k = 0; k < 3; k++) begin
      wr(AC, {7'h0, k == 0});
      pin_at(k != 1);
      rd(AI, (k < 2) ? 8'h7a : 8'h78);
      wr(AI, 8'h78);
    end
    `CHK("nvec", 0, nv)
    done("flags");
    wr(AE, 8'h40);
    wr(AI, 8'hc0);
    cm.pulse(3);
    wvec();
    `CHK("lat", 1'b1, n >= 12 && n <= 17)
    `CHK("vaddr", irq_ctrl_pkg::IRQ_VECTOR, core.vector_addr)
    `CHK("spc", 16'h0123, spc)
    @(posedge clk);
    `CHK("vpulse", 1'b0, core.vector_req)
    rd(AI, 8'h40);
    repeat (30) @(posedge clk);
    `CHK("nvec", 1, nv)
    // flag cleared before re-enabling
    wr(AF, 8'h00);
    cm.ret();
    rd(AI, 8'hc0);
    wr(AI, 8'h80);
    cm.pulse(3);
    repeat (30) @(posedge clk);
    `CHK("nvec", 1, nv)
    wr(AI, 8'hc0);
    wvec();
    @(posedge clk);
    `CHK("nvec", 2, nv)
    `CHK("spc", 16'h0133, spc)
    wr(AF, 8'h00);
    cm.ret();
    cm.pulse(3);
    wr(AI, 8'h40);
    repeat (30) @(posedge clk);
    `CHK("nvec", 2, nv)
    wr(AI, 8'hc0);
    wvec();
    @(posedge clk);
    `CHK("nvec", 3, nv)
    wr(AF, 8'h00);
    cm.ret();
    done("vector");
    wr(AI, 8'h08);
    wr(AC, 8'h02);
    `CHK("wake", 1'b0, core.wake)
    mask <= 6'h3f;
    port <= 6'h01;
    repeat (12) @(posedge clk);
    `CHK("wake", 1'b1, core.wake)
    rd(AI, 8'h09);
    `CHK("nvec", 3, nv)
    mask <= '0;
    wr(AC, 8'h00);
    wr(AI, 8'h81);
    reset(1'b0, 3);
    rd(AI, 8'h01);
    rd(AF, 8'h00);
    reset(1'b1, 3);
    `CHK("qph", irq_ctrl_pkg::Q1, qph)
    rd(AI, 8'h00);
    done("reset");
    results();
  end
endmodule
